// ---- sae_report.sv ----
`timescale 1ns/1ps
module sae_report
  import sae_pkg::*;
#(
  parameter int QDEPTH = EMCY_QUEUE_DEPTH
) (
  input wire logic mclk, // 200 MHz system clock
  input wire logic resetn, // Async reset, active low
  input wire logic req_valid, // Service-data request strobe
  input wire sae_req_s req, // Request with checker verdict
  output sae_rsp_s rsp, // Response or abort
  output logic rsp_valid, // Response strobe
  input wire sae_esm_e esm_state, // Current ESM state
  input wire logic alarm_event, // New drive alarm pulse
  input wire logic warning_event, // Warning pulse, never reported
  input wire sae_emcy_s alarm_info, // Emergency content for alarm
  output sae_emcy_s emcy, // Emergency message out
  output logic emcy_valid, // Emergency held for mailbox
  input wire logic emcy_ready, // Mailbox took the message
  output logic [15:0] flags // Diagnosis flag word
);
  localparam int PW = $clog2(QDEPTH);

  sae_emcy_s queue [QDEPTH];
  sae_emcy_s next_queue [QDEPTH];
  logic [PW-1:0] rd_ptr, next_rd_ptr;
  logic [PW:0] count, next_count;
  logic emcy_en, next_emcy_en;
  sae_rsp_s next_rsp;
  logic next_rsp_valid;
  sae_emcy_s next_emcy;
  logic next_emcy_valid;
  logic [15:0] next_flags;

  // Priority follows the order in which a real access would fail
  function automatic logic [31:0] abort_code(input sae_fault_s f);
    logic [31:0] c;
    c = 32'h00000000;
    if (f.no_dict) c = ABORT_NO_DICT;
    else if (f.hw_fault) c = ABORT_HW_FAULT;
    else if (f.cmd_unknown) c = ABORT_BAD_CMD;
    else if (f.no_index) c = ABORT_NO_INDEX;
    else if (f.no_subindex) c = ABORT_NO_SUBINDEX;
    else if (f.access_unsupported) c = ABORT_ACCESS;
    else if (f.read_only) c = ABORT_READ_ONLY;
    else if (f.si0_nonzero) c = ABORT_SI0_NONZERO;
    else if (f.length_mismatch) c = ABORT_LENGTH;
    else if (f.too_high) c = ABORT_TOO_HIGH;
    else if (f.too_low) c = ABORT_TOO_LOW;
    else if (f.range_general) c = ABORT_RANGE;
    else if (f.max_lt_min) c = ABORT_MAX_LT_MIN;
    else if (f.state_refused) c = ABORT_DEV_STATE;
    else if (f.app_refused) c = ABORT_APP;
    return c;
  endfunction : abort_code

  logic is_flags, is_write, failed;
  logic [31:0] code;
  logic [PW-1:0] wr_ptr;
  logic push, pop, send_ok;

  always_comb begin
    is_flags = (req.index == FLAGS_INDEX) && (req.subindex == FLAGS_SUBINDEX);
    is_write = (req.kind == SAE_KIND_WRITE);
    code = abort_code(req.fault);
    // The flag word's read-only bits are checked here, not by the dictionary
    if (code == 32'h00000000 && is_flags && is_write &&
        ((req.wdata & 16'hFFFE) != (FLAGS_FIXED & 16'hFFFE))) begin
      code = ABORT_READ_ONLY;
    end
    failed = (code != 32'h00000000);
    send_ok = (esm_state != SAE_ESM_INIT);
    pop = emcy_valid && emcy_ready;
    push = alarm_event && emcy_en;
  end

  always_comb begin
    next_rsp = rsp;
    next_rsp_valid = 1'b0;
    next_emcy_en = emcy_en;
    if (req_valid && !req.cyclic) begin
      next_rsp_valid = 1'b1;
      next_rsp.index = req.index;
      next_rsp.subindex = req.subindex;
      next_rsp.abort = failed;
      if (failed) begin
        next_rsp.data = code;
      end else if (is_flags && !is_write) begin
        next_rsp.data = {16'h0000, flags};
      end else begin
        next_rsp.data = 32'h00000000;
      end
      if (!failed && is_flags && is_write) begin
        next_emcy_en = req.wdata[FLAG_EMCY_EN_BIT];
      end
    end
    next_flags = FLAGS_FIXED;
    next_flags[FLAG_EMCY_EN_BIT] = next_emcy_en;
  end

  always_comb begin
    next_queue = queue;
    next_rd_ptr = rd_ptr;
    next_count = count;
    next_emcy = emcy;
    next_emcy_valid = emcy_valid;
    if (pop) begin
      next_emcy_valid = 1'b0;
    end
    // Head moves out before the push, so a full queue overwrites it unread only when it cannot move out
    if (!next_emcy_valid && count != '0 && send_ok && emcy_en) begin
      next_emcy = queue[rd_ptr];
      next_emcy_valid = 1'b1;
      next_rd_ptr = PW'(rd_ptr + 1'b1);
      next_count = count - 1'b1;
    end
    wr_ptr = PW'(next_rd_ptr + PW'(next_count));
    if (push) begin
      if (!next_emcy_valid && send_ok) begin
        // Queue is empty here, so the alarm goes straight to the output slot
        next_emcy = alarm_info;
        next_emcy_valid = 1'b1;
      end else if (next_count == (PW+1)'(QDEPTH)) begin
        // Full: oldest entry is dropped so the latest alarms survive
        next_queue[next_rd_ptr] = alarm_info;
        next_rd_ptr = PW'(next_rd_ptr + 1'b1);
      end else begin
        next_queue[wr_ptr] = alarm_info;
        next_count = next_count + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rsp <= '0;
      rsp_valid <= 1'b0;
      emcy_en <= FLAG_EMCY_EN_RESET;
      flags <= {FLAGS_FIXED[15:1], FLAG_EMCY_EN_RESET};
    end else begin
      rsp <= next_rsp;
      rsp_valid <= next_rsp_valid;
      emcy_en <= next_emcy_en;
      flags <= next_flags;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      emcy <= '0;
      emcy_valid <= 1'b0;
      rd_ptr <= '0;
      count <= '0;
      for (int i = 0; i < QDEPTH; i++) begin
        queue[i] <= '0;
      end
    end else begin
      emcy <= next_emcy;
      emcy_valid <= next_emcy_valid;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      queue <= next_queue;
    end
  end
endmodule : sae_report

// ---- sae_pkg.sv ----
// Contract
// - Failed service-data access returns abort code.
// - No abort for cyclic process data.
// - Unknown command specifier aborts 05040001h.
// - Access kind, read-only, subindex-zero write aborts.
// - Missing index or sub-index abort codes.
// - Length/type mismatch aborts 06070010h.
// - Range, too high, too low aborts.
// - Maximum below minimum aborts 06090036h.
// - Hardware fault aborts 06060000h.
// - Application, device state, dictionary aborts.
// - Never emit unsupported abort codes.
// - Alarm sends emergency message via mailbox.
// - Warning alone sends no emergency.
// - Queue eight Init emergencies, deliver at PreOP.
// - Beyond eight, discard oldest, keep eight.
// - Flag bit 0 gates emergency transmission.
// - Emergency enable defaults to one.
// - Flag bits 1 and 2 read one.
// - Flag bit 3 reads zero.
// - Emergency is eight bytes: code, register, field.
package sae_pkg;
  localparam logic [31:0] ABORT_BAD_CMD = 32'h05040001;
  localparam logic [31:0] ABORT_ACCESS = 32'h06010000;
  localparam logic [31:0] ABORT_READ_ONLY = 32'h06010002;
  localparam logic [31:0] ABORT_SI0_NONZERO = 32'h06010003;
  localparam logic [31:0] ABORT_NO_INDEX = 32'h06020000;
  localparam logic [31:0] ABORT_HW_FAULT = 32'h06060000;
  localparam logic [31:0] ABORT_LENGTH = 32'h06070010;
  localparam logic [31:0] ABORT_NO_SUBINDEX = 32'h06090011;
  localparam logic [31:0] ABORT_RANGE = 32'h06090030;
  localparam logic [31:0] ABORT_TOO_HIGH = 32'h06090031;
  localparam logic [31:0] ABORT_TOO_LOW = 32'h06090032;
  localparam logic [31:0] ABORT_MAX_LT_MIN = 32'h06090036;
  localparam logic [31:0] ABORT_APP = 32'h08000020;
  localparam logic [31:0] ABORT_DEV_STATE = 32'h08000022;
  localparam logic [31:0] ABORT_NO_DICT = 32'h08000023;
  localparam logic [15:0] FLAGS_INDEX = 16'h10F3;
  localparam logic [7:0] FLAGS_SUBINDEX = 8'h05;
  localparam int FLAG_EMCY_EN_BIT = 0;
  localparam logic FLAG_EMCY_EN_RESET = 1'b1;
  localparam logic [15:0] FLAGS_FIXED = 16'h0006;
  localparam int EMCY_QUEUE_DEPTH = 8;
  localparam int EMCY_BYTES = 8;

  typedef enum logic [1:0] {
    SAE_ESM_INIT = 2'b00,
    SAE_ESM_PREOP = 2'b01,
    SAE_ESM_SAFEOP = 2'b10,
    SAE_ESM_OP = 2'b11
  } sae_esm_e;

  typedef enum logic [2:0] {
    SAE_KIND_READ = 3'b000,
    SAE_KIND_WRITE = 3'b001,
    SAE_KIND_OTHER = 3'b010
  } sae_kind_e;

  // Fault conditions found by the dictionary checker for one request
  typedef struct packed {
    logic cmd_unknown;
    logic access_unsupported;
    logic read_only;
    logic si0_nonzero;
    logic no_index;
    logic no_subindex;
    logic length_mismatch;
    logic range_general;
    logic too_high;
    logic too_low;
    logic max_lt_min;
    logic hw_fault;
    logic app_refused;
    logic state_refused;
    logic no_dict;
  } sae_fault_s;

  typedef struct packed {
    logic cyclic;
    sae_kind_e kind;
    logic [15:0] index;
    logic [7:0] subindex;
    logic [15:0] wdata;
    sae_fault_s fault;
  } sae_req_s;

  typedef struct packed {
    logic abort;
    logic [15:0] index;
    logic [7:0] subindex;
    logic [31:0] data;
  } sae_rsp_s;

  typedef struct packed {
    logic [15:0] err_code;
    logic [7:0] err_reg;
    logic [39:0] mfr_field;
  } sae_emcy_s;
endpackage : sae_pkg

// ---- sae_report_properties.sv ----
`timescale 1ns/1ps
module sae_report_properties
  import sae_pkg::*;
#(parameter int QDEPTH = EMCY_QUEUE_DEPTH) (
  input wire logic mclk, // Clock
  input wire logic resetn, // Reset
  input wire logic req_valid, // Strobe
  input wire sae_req_s req, // Request
  input wire sae_rsp_s rsp, // Answer
  input wire logic rsp_valid, // Answer strobe
  input wire sae_esm_e esm_state, // State
  input wire logic alarm_event, // Alarm
  input wire logic warning_event, // Warning
  input wire sae_emcy_s alarm_info, // Alarm data
  input wire sae_emcy_s emcy, // Message
  input wire logic emcy_valid, // Offered
  input wire logic emcy_ready, // Taken
  input wire logic [15:0] flags // Flag word
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  wire logic tk = req_valid && !req.cyclic;
  rsp_lat_a: assert property (tk |=> rsp_valid) else $error("late answer");
  no_cyc_a: assert property (!tk |=> !rsp_valid) else $error("stray answer");
  bad_cmd_a: assert property (tk && req.fault == 15'h4000 |=> rsp.abort && rsp.data == ABORT_BAD_CMD)
    else $error("bad command code");
  hw_code_a: assert property (tk && req.fault == 15'h0008 |=> rsp.data == ABORT_HW_FAULT)
    else $error("fault code");
  echo_ids_a: assert property (tk |=> rsp.index == $past(req.index) && rsp.subindex == $past(req.subindex))
    else $error("ids not echoed");
  no_unsup_a: assert property (rsp_valid |-> !(rsp.abort && rsp.data inside {32'h05030000, 32'h05040000,
    32'h08000000})) else $error("unsupported code");
  emcy_hold_a: assert property (emcy_valid && !emcy_ready |=> emcy_valid && $stable(emcy))
    else $error("message dropped");
  init_hold_a: assert property (esm_state == SAE_ESM_INIT && !emcy_valid |=> !emcy_valid)
    else $error("sent in init");
  en_gate_a: assert property (!flags[0] && !emcy_valid |=> !emcy_valid) else $error("sent while off");
  flag_reset_a: assert property ($rose(resetn) |-> flags == 16'h0007) else $error("flag reset");
  fixed_one_a: assert property (flags[2:1] == 2'b11) else $error("bits one two");
  bit3_zero_a: assert property (!flags[3]) else $error("bit three");
endmodule : sae_report_properties
bind sae_report sae_report_properties #(.QDEPTH(QDEPTH)) i_sae_report_properties (.mclk(mclk), .resetn(resetn),
  .req_valid(req_valid), .req(req), .rsp(rsp), .rsp_valid(rsp_valid), .esm_state(esm_state),
  .alarm_event(alarm_event), .warning_event(warning_event), .alarm_info(alarm_info), .emcy(emcy),
  .emcy_valid(emcy_valid), .emcy_ready(emcy_ready), .flags(flags));

// ---- sae_mbx_model.sv ----
`timescale 1ns/1ps
module sae_mbx_model (
  input wire logic mclk, // Clock
  input wire logic resetn, // Reset
  input wire logic emcy_valid, // Offered
  input wire logic slow, // Busy mailbox
  output logic emcy_ready // Taken
);
  logic [1:0] cnt;
  logic [1:0] next_cnt;
  always_comb next_cnt = cnt + 2'h1;
  always_ff @(posedge mclk or negedge resetn) if (!resetn) cnt <= 2'h0; else cnt <= next_cnt;
  // A busy mailbox takes one message in four cycles
  assign emcy_ready = emcy_valid && (!slow || cnt == 2'h0);
endmodule : sae_mbx_model

// ---- sae_report_tb.sv ----
`timescale 1ns/1ps
module sae_report_tb;
  import sae_pkg::*;
  localparam logic [31:0] CODES [15] = '{ABORT_NO_DICT, ABORT_DEV_STATE, ABORT_APP, ABORT_HW_FAULT,
    ABORT_MAX_LT_MIN, ABORT_TOO_LOW, ABORT_TOO_HIGH, ABORT_RANGE, ABORT_LENGTH, ABORT_NO_SUBINDEX,
    ABORT_NO_INDEX, ABORT_SI0_NONZERO, ABORT_READ_ONLY, ABORT_ACCESS, ABORT_BAD_CMD};
  logic mclk = 0, resetn = 0, req_valid = 0, alarm_event = 0, warning_event = 0, slow = 0;
  logic rsp_valid, emcy_valid, emcy_ready;
  logic [15:0] flags;
  sae_req_s req = '0;
  sae_rsp_s rsp;
  sae_esm_e esm_state = SAE_ESM_PREOP;
  sae_emcy_s alarm_info = '0, emcy;
  int fail_count = 0, samples_checked = 0;
  sae_rsp_s rq[$];
  sae_emcy_s eq[$];
  always #2.5 mclk = ~mclk;
  sae_report i_sae_report (.mclk(mclk), .resetn(resetn), .req_valid(req_valid), .req(req), .rsp(rsp),
    .rsp_valid(rsp_valid), .esm_state(esm_state), .alarm_event(alarm_event), .warning_event(warning_event),
    .alarm_info(alarm_info), .emcy(emcy), .emcy_valid(emcy_valid), .emcy_ready(emcy_ready), .flags(flags));
  sae_mbx_model i_sae_mbx_model (.mclk(mclk), .resetn(resetn), .emcy_valid(emcy_valid), .slow(slow),
    .emcy_ready(emcy_ready));
  task chk(input string n, input logic [63:0] s, e);
    samples_checked++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", n, e, s);
    end
  endtask : chk
  task print_verdict;
    $display("checks %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  task tx(input sae_kind_e k, input logic [15:0] i, input logic [7:0] s, input logic [15:0] w,
    input sae_fault_s f, input logic c, input logic a, input logic [31:0] d);
    @(posedge mclk);
    req_valid <= 1'b1;
    req <= '{c, k, i, s, w, f};
    if (!c) rq.push_back('{a, i, s, d});
  endtask : tx
  task alarm(input logic en);
    sae_emcy_s m;
    @(posedge mclk);
    m = {$urandom, $urandom};
    alarm_event <= 1'b1;
    alarm_info <= m;
    if (en) eq.push_back(m);
  endtask : alarm
  task idle(input int n);
    @(posedge mclk);
    req_valid <= 1'b0;
    alarm_event <= 1'b0;
    warning_event <= 1'b0;
    repeat (n) @(posedge mclk);
  endtask : idle
  // An answer or message with nothing expected compares against unknown and fails
  always @(posedge mclk) begin
    if (resetn && rsp_valid) chk("rsp", rsp, rq.size() ? rq.pop_front() : 'x);
    if (resetn && emcy_valid && emcy_ready) chk("emcy", emcy, eq.size() ? eq.pop_front() : 'x);
  end
  initial begin
    int b;
    b = $urandom(26186);
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    chk("flags", flags, 16'h0007);
    for (b = 0; b < 15; b++) tx(sae_kind_e'(b % 2), {4'h2, 12'($urandom)}, 8'($urandom), 16'h0,
      sae_fault_s'(15'h1 << b), 1'b0, 1'b1, CODES[b]);
    tx(SAE_KIND_WRITE, 16'h2001, 8'h1, 16'h0, '1, 1'b0, 1'b1, ABORT_NO_DICT);
    tx(SAE_KIND_READ, 16'h2002, 8'h0, 16'h0, '1, 1'b1, 1'b0, 32'h0);
    tx(SAE_KIND_READ, FLAGS_INDEX, FLAGS_SUBINDEX, 16'h0, '0, 1'b0, 1'b0, 32'h7);
    tx(SAE_KIND_WRITE, FLAGS_INDEX, FLAGS_SUBINDEX, 16'h000F, '0, 1'b0, 1'b1, ABORT_READ_ONLY);
    tx(SAE_KIND_WRITE, FLAGS_INDEX, FLAGS_SUBINDEX, 16'h0006, '0, 1'b0, 1'b0, 32'h0);
    idle(2);
    chk("flags", flags, 16'h0006);
    alarm(1'b0);
    idle(2);
    tx(SAE_KIND_READ, FLAGS_INDEX, FLAGS_SUBINDEX, 16'h0, '0, 1'b0, 1'b0, 32'h6);
    tx(SAE_KIND_WRITE, FLAGS_INDEX, FLAGS_SUBINDEX, 16'h0007, '0, 1'b0, 1'b0, 32'h0);
    idle(2);
    warning_event <= 1'b1;
    idle(4);
    alarm(1'b1);
    idle(3);
    esm_state <= SAE_ESM_INIT;
    slow <= 1'b1;
    for (b = 0; b < 10; b++) alarm(b >= 2);
    idle(5);
    esm_state <= SAE_ESM_SAFEOP;
    for (b = 0; b < 400 && (rq.size() || eq.size()); b++) @(posedge mclk);
    if (b == 400) fail_count++;
    print_verdict();
  end
endmodule : sae_report_tb
